//--- verilog/twi_regs.vh
// Register map, field positions and constants of the trap and wakeup interrupt block
`ifndef TWI_REGS_VH
`define TWI_REGS_VH

// APB byte offsets
`define TWI_OFF_CTRL      12'h000
`define TWI_OFF_WAKE_EN   12'h004
`define TWI_OFF_WAKE_EDG  12'h008
`define TWI_OFF_WAKE_PND  12'h00c
`define TWI_OFF_STATUS    12'h010

// Control register fields
`define TWI_CTRL_GIE_BIT   0
`define TWI_CTRL_PORT_GROUP_IRQ_ENABLE_BIT  1

// Status register fields
`define TWI_STAT_REQ_BIT   0
`define TWI_STAT_WAKE_BIT  1
`define TWI_STAT_SVC_BIT   2

// Reset values
`define TWI_CTRL_RST      2'h0
`define TWI_WAKE_EN_RST   8'h00
`define TWI_WAKE_EDG_RST  8'h00
`define TWI_WAKE_PND_RST  8'h00

// Opcodes and vectors
`define TWI_OP_TRAP       8'h00
`define TWI_VEC_TRAP      8'hfe
`define TWI_VEC_WAKE      8'he2
`define TWI_VEC_DEFAULT   8'he0

`endif

//--- verilog/twi_trap_wakeup.v
// Software trap and port wakeup interrupt logic with an APB register slave
`timescale 1ns/1ps
`default_nettype none
`include "twi_regs.vh"

module twi_trap_wakeup #(
    parameter PORT_W = 8,
    parameter PC_W   = 15,
    parameter ROM_TOP = 15'h2fff
) (
    input  wire              clk_sys_in,
    input  wire              rstn_in,
    input  wire              ce_in,
    // APB slave
    input  wire              psel_in,
    input  wire              penable_in,
    input  wire              pwrite_in,
    input  wire [11:0]       paddr_in,
    input  wire [31:0]       pwdata_in,
    input  wire [3:0]        pstrb_in,
    output reg  [31:0]       prdata_out,
    output reg               pready_out,
    output reg               pslverr_out,
    // Core fetch side
    input  wire              fetch_valid_in,
    input  wire [PC_W-1:0]   fetch_pc_in,
    input  wire [7:0]        rom_data_in,
    output reg  [7:0]        fetch_opcode_out,
    output reg               fetch_valid_out,
    input  wire              stack_pop_under_in,
    input  wire              clear_trap_pending_op_in,
    input  wire              vector_select_op_in,
    input  wire              interrupt_return_op_in,
    input  wire [PORT_W-1:0] ext_pending_in,
    input  wire              halt_idle_in,
    output reg               trap_req_out,
    output reg  [PC_W-1:0]   trap_ret_pc_out,
    output reg               irq_req_out,
    output reg  [7:0]        vector_low_out,
    output reg               vector_valid_out,
    output reg               wake_out,
    output reg               wake_service_out,
    output reg               load_pc_top_out,
    // Port pins
    input  wire [PORT_W-1:0] port_pins_in
);

    // Idle / maskable-service state, one-hot
    localparam [1:0] ST_RUN = 2'b01;
    localparam [1:0] ST_SVC = 2'b10;

    reg [1:0]        state;
    reg [1:0]        next_state;
    reg              trap_pending_flag;
    reg              global_irq_enable;
    reg              port_group_irq_enable;
    reg [PORT_W-1:0] wake_enable_bits;
    reg [PORT_W-1:0] wake_edge_select;
    reg [PORT_W-1:0] wake_pending_bits;
    reg [PORT_W-1:0] pins_last;

    wire apb_wr = psel_in & penable_in & pwrite_in & ~pready_out;
    wire apb_rd = psel_in & penable_in & ~pwrite_in & ~pready_out;

    function valid_offset;
        input [11:0] a;
        begin
            case (a)
                `TWI_OFF_CTRL,
                `TWI_OFF_WAKE_EN,
                `TWI_OFF_WAKE_EDG,
                `TWI_OFF_WAKE_PND,
                `TWI_OFF_STATUS: valid_offset = 1'b1;
                default:         valid_offset = 1'b0;
            endcase
        end
    endfunction

    // Unprogrammed space decodes as the trap opcode
    wire        rom_hole   = (fetch_pc_in > ROM_TOP);
    wire [7:0]  opcode     = rom_hole ? `TWI_OP_TRAP : rom_data_in;
    wire        trap_fetch = fetch_valid_in & (opcode == `TWI_OP_TRAP);

    // Per-pin edge detection; edge select 1 = rising, 0 = falling
    wire [PORT_W-1:0] edge_hit;
    genvar g;
    generate
        for (g = 0; g < PORT_W; g = g + 1) begin : g_edge
            assign edge_hit[g] = wake_edge_select[g] ?
                                 (port_pins_in[g] & ~pins_last[g]) :
                                 (~port_pins_in[g] & pins_last[g]);
        end
    endgenerate

    wire [PORT_W-1:0] wake_active = wake_pending_bits & wake_enable_bits;
    wire port_req = |wake_active & port_group_irq_enable & global_irq_enable;
    // Trap flag locks out all maskables; no nesting of maskables
    wire mask_ok  = ~trap_pending_flag & (state == ST_RUN);
    wire any_ext  = |ext_pending_in;

    // Wake pending byte-lane write mask, write-one-to-clear
    wire [PORT_W-1:0] pnd_clr = (apb_wr && paddr_in == `TWI_OFF_WAKE_PND && pstrb_in[0]) ?
                                pwdata_in[PORT_W-1:0] : {PORT_W{1'b0}};

    always @* begin
        next_state = state;
        case (state)
            ST_RUN: begin
                if (vector_select_op_in && mask_ok && global_irq_enable &&
                    (port_req || any_ext)) begin
                    next_state = ST_SVC;
                end
            end
            ST_SVC: begin
                if (interrupt_return_op_in) begin
                    next_state = ST_RUN;
                end
            end
            default: next_state = ST_RUN;
        endcase
    end

    // Next-value logic for the flops below
    reg [7:0]  next_vector_low;
    reg [31:0] next_prdata;
    reg        next_trap_pending;
    reg        next_irq_req;
    reg        next_pready;
    reg        next_pslverr;
    reg        next_wake;
    reg        next_wake_service;

    // Nested traps share one flag; an inner clear also frees the outer routine
    always @* begin
        next_trap_pending = trap_pending_flag;
        // Trap set wins over a simultaneous clear op
        if (trap_fetch) begin
            next_trap_pending = 1'b1;
        end else if (clear_trap_pending_op_in) begin
            next_trap_pending = 1'b0;
        end
    end

    // Trap requests bypass every enable; maskables need the lock-out clear
    always @* begin
        next_irq_req = 1'b0;
        if (trap_pending_flag || trap_fetch) begin
            next_irq_req = 1'b1;
        end else if (mask_ok && global_irq_enable && (port_req || any_ext)) begin
            next_irq_req = 1'b1;
        end
    end

    // Vector arbitration: trap first, then external ranks, then the port group
    always @* begin
        next_vector_low = `TWI_VEC_DEFAULT;
        if (trap_pending_flag) begin
            next_vector_low = `TWI_VEC_TRAP;
        end else if (any_ext && global_irq_enable) begin
            next_vector_low = ext_vector(ext_pending_in);
        end else if (port_req) begin
            next_vector_low = `TWI_VEC_WAKE;
        end
    end

    // In halt, wake needs only an enabled pending pin; service also needs both enables
    always @* begin
        next_wake         = 1'b0;
        next_wake_service = 1'b0;
        if (halt_idle_in) begin
            next_wake         = |wake_active;
            next_wake_service = port_req;
        end
    end

    // One wait state: the answer comes on the second access cycle
    always @* begin
        next_pready  = 1'b0;
        next_pslverr = 1'b0;
        if (psel_in && penable_in && !pready_out) begin
            next_pready  = 1'b1;
            next_pslverr = ~valid_offset(paddr_in);
        end
    end

    // Read mux; the trap flag is deliberately absent from every word
    always @* begin
        next_prdata = 32'h0000_0000;
        if (apb_rd) begin
            case (paddr_in)
                `TWI_OFF_CTRL: begin
                    next_prdata = {30'h0, port_group_irq_enable, global_irq_enable};
                end
                `TWI_OFF_WAKE_EN: begin
                    next_prdata = {{(32-PORT_W){1'b0}}, wake_enable_bits};
                end
                `TWI_OFF_WAKE_EDG: begin
                    next_prdata = {{(32-PORT_W){1'b0}}, wake_edge_select};
                end
                `TWI_OFF_WAKE_PND: begin
                    next_prdata = {{(32-PORT_W){1'b0}}, wake_pending_bits};
                end
                `TWI_OFF_STATUS: begin
                    next_prdata = {29'h0, state == ST_SVC, |wake_active, port_req};
                end
                default: begin
                    next_prdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // Control state and the hidden trap flag
    always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state             <= ST_RUN;
            trap_pending_flag <= 1'b0;
        end else if (ce_in) begin
            state             <= next_state;
            trap_pending_flag <= next_trap_pending;
        end
    end

    // One pending latch per pin, held until software writes a one to it
    localparam [PORT_W-1:0] PND_RST = `TWI_WAKE_PND_RST;
    generate
        for (g = 0; g < PORT_W; g = g + 1) begin : g_pend
            always @(posedge clk_sys_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    wake_pending_bits[g] <= PND_RST[g];
                end else if (ce_in) begin
                    // A new edge wins over a software clear
                    if (edge_hit[g]) begin
                        wake_pending_bits[g] <= 1'b1;
                    end else if (pnd_clr[g]) begin
                        wake_pending_bits[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Pin history and wake from halt
    always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pins_last        <= {PORT_W{1'b0}};
            wake_out         <= 1'b0;
            wake_service_out <= 1'b0;
        end else if (ce_in) begin
            pins_last        <= port_pins_in;
            wake_out         <= next_wake;
            wake_service_out <= next_wake_service;
        end
    end

    // Fetch path, trap acknowledge and over-pop redirect
    always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            fetch_opcode_out <= 8'h00;
            fetch_valid_out  <= 1'b0;
            trap_req_out     <= 1'b0;
            trap_ret_pc_out  <= {PC_W{1'b0}};
            load_pc_top_out  <= 1'b0;
            irq_req_out      <= 1'b0;
        end else if (ce_in) begin
            fetch_opcode_out <= opcode;
            fetch_valid_out  <= fetch_valid_in;
            // No enable gates the acknowledge, so a trap is never lost
            trap_req_out     <= trap_fetch;
            if (trap_fetch) begin
                trap_ret_pc_out <= fetch_pc_in;
            end
            load_pc_top_out  <= stack_pop_under_in;
            irq_req_out      <= next_irq_req;
        end
    end

    // Vector is taken in every cycle that the select op is high
    always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            vector_low_out   <= `TWI_VEC_DEFAULT;
            vector_valid_out <= 1'b0;
        end else if (ce_in) begin
            vector_valid_out <= vector_select_op_in;
            if (vector_select_op_in) begin
                vector_low_out <= next_vector_low;
            end
        end
    end

    // Enable bits; a trap leaves the global enable alone
    always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            global_irq_enable     <= 1'b0;
            port_group_irq_enable <= 1'b0;
        end else if (ce_in && apb_wr && pstrb_in[0] && paddr_in == `TWI_OFF_CTRL) begin
            global_irq_enable     <= pwdata_in[`TWI_CTRL_GIE_BIT];
            port_group_irq_enable <= pwdata_in[`TWI_CTRL_PORT_GROUP_IRQ_ENABLE_BIT];
        end
    end

    // Per-pin configuration; only the low byte lane carries the port bits
    always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wake_enable_bits <= `TWI_WAKE_EN_RST;
            wake_edge_select <= `TWI_WAKE_EDG_RST;
        end else if (ce_in && apb_wr && pstrb_in[0]) begin
            case (paddr_in)
                `TWI_OFF_WAKE_EN: begin
                    wake_enable_bits <= pwdata_in[PORT_W-1:0];
                end
                `TWI_OFF_WAKE_EDG: begin
                    wake_edge_select <= pwdata_in[PORT_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Bus answer flops; read data is zero outside the answer cycle
    always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0000_0000;
        end else if (ce_in) begin
            pready_out  <= next_pready;
            pslverr_out <= next_pslverr;
            prdata_out  <= next_prdata;
        end
    end

    // Lowest-numbered external source has the highest rank, vectors fa down to ec
    function [7:0] ext_vector;
        input [PORT_W-1:0] p;
        integer i;
        begin
            ext_vector = `TWI_VEC_DEFAULT;
            for (i = PORT_W - 1; i >= 0; i = i - 1) begin
                if (p[i]) begin
                    ext_vector = 8'hfa - {i[6:0], 1'b0};
                end
            end
        end
    endfunction

endmodule
`default_nettype wire

//--- testbench/twi_trap_wakeup_sva.sv
// Port-level checker for the trap and wakeup interrupt block
`timescale 1ns/1ps
`default_nettype none
module twi_trap_wakeup_sva #(
    parameter PC_W    = 15,
    parameter ROM_TOP = 15'h2fff
) (
    input wire logic            clk_sys_in,
    input wire logic            rstn_in,
    input wire logic            ce_in,
    input wire logic            psel_in,
    input wire logic            penable_in,
    input wire logic            pready_out,
    input wire logic            fetch_valid_in,
    input wire logic [PC_W-1:0] fetch_pc_in,
    input wire logic [7:0]      rom_data_in,
    input wire logic [7:0]      fetch_opcode_out,
    input wire logic            stack_pop_under_in,
    input wire logic            load_pc_top_out,
    input wire logic            vector_select_op_in,
    input wire logic [7:0]      vector_low_out,
    input wire logic            vector_valid_out,
    input wire logic            trap_req_out,
    input wire logic [PC_W-1:0] trap_ret_pc_out,
    input wire logic            irq_req_out,
    input wire logic            wake_out,
    input wire logic            wake_service_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    a_trap_on_fetch: assert property (fetch_valid_in && ce_in && (rom_data_in == 8'h00
        || fetch_pc_in > ROM_TOP) |=> trap_req_out && trap_ret_pc_out == $past(fetch_pc_in))
        else $error("trap not raised on zero opcode fetch");
    a_trap_cause: assert property (trap_req_out |-> $past(fetch_valid_in))
        else $error("trap raised without a fetch");
    a_unmapped_zero: assert property (fetch_valid_in && ce_in && fetch_pc_in > ROM_TOP
        |=> fetch_opcode_out == 8'h00) else $error("unmapped fetch not zero");
    a_trap_immediate: assert property (trap_req_out |-> irq_req_out)
        else $error("trap not requested at once");
    a_pop_top: assert property (stack_pop_under_in && ce_in |=> load_pc_top_out)
        else $error("over-pop did not load top address");
    a_vector_even: assert property (vector_select_op_in && ce_in |=> vector_valid_out
        && !vector_low_out[0] && vector_low_out >= 8'he0) else $error("bad vector");
    a_apb_answer: assert property (psel_in && penable_in && ce_in && !pready_out
        |=> pready_out ##1 !pready_out) else $error("apb answer late or long");
    a_wake_service: assert property (wake_service_out |-> wake_out)
        else $error("service without wake");
endmodule
`default_nettype wire

//--- testbench/twi_core_model.sv
// Core fetch and instruction model facing the interrupt block
`timescale 1ns/1ps
`default_nettype none
module twi_core_model (
    input  wire logic        clk_in,
    output var  logic        fetch_valid_out,
    output var  logic [14:0] fetch_pc_out,
    output var  logic [7:0]  rom_data_out,
    output var  logic [3:0]  op_out
);
    initial begin
        fetch_valid_out = 1'b0;
        fetch_pc_out = 15'h0000;
        rom_data_out = 8'hff;
        op_out = 4'h0;
    end
    task fetch(input logic [14:0] a, input logic [7:0] d);
        @(posedge clk_in);
        fetch_valid_out <= 1'b1;
        fetch_pc_out <= a;
        rom_data_out <= d;
        @(posedge clk_in);
        fetch_valid_out <= 1'b0;
        // Released bus shows the inverse, not a stale match
        rom_data_out <= ~d;
    endtask
    // Bit 0 over-pop, 1 clear flag, 2 vector select, 3 return
    task op(input int k);
        @(posedge clk_in);
        op_out <= 4'h1 << k;
        @(posedge clk_in);
        op_out <= 4'h0;
    endtask
    task recover;
        op(1);
        op(1);
    endtask
endmodule
`default_nettype wire

//--- testbench/twi_trap_wakeup_bench.sv
// Self-checking bench for the trap and wakeup interrupt block
`timescale 1ns/1ps
`default_nettype none
module twi_trap_wakeup_bench;
    logic clk_sys_in = 0, rstn_in = 0, ce_in = 1, psel_in = 0, penable_in = 0;
    logic pwrite_in = 0, halt_idle_in = 0, e;
    logic [3:0] pstrb_in = 4'hf;
    logic [11:0] paddr_in = 0;
    logic [31:0] pwdata_in = 0, prdata_out, q;
    logic [7:0] fetch_opcode_out, vector_low_out, ext_pending_in = 0, port_pins_in = 8'h80;
    logic [14:0] trap_ret_pc_out;
    wire logic [14:0] fetch_pc_in;
    wire logic [7:0] rom_data_in;
    wire logic fetch_valid_in, stack_pop_under_in, clear_trap_pending_op_in;
    wire logic vector_select_op_in, interrupt_return_op_in;
    logic pready_out, pslverr_out, fetch_valid_out, trap_req_out, irq_req_out;
    logic vector_valid_out, wake_out, wake_service_out, load_pc_top_out;
    int mismatches = 0, num_checks = 0, cyc = 0;
    always #12.5 clk_sys_in = ~clk_sys_in;
    twi_trap_wakeup u_twi_trap_wakeup (.*);
    twi_core_model u_twi_core_model (.clk_in(clk_sys_in), .fetch_valid_out(fetch_valid_in),
        .fetch_pc_out(fetch_pc_in), .rom_data_out(rom_data_in), .op_out({interrupt_return_op_in,
        vector_select_op_in, clear_trap_pending_op_in, stack_pop_under_in}));
    task wrap_up;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] x, input logic [31:0] g);
        num_checks++;
        if (g !== x) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, x, g);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys_in);
        psel_in <= 1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_sys_in);
        penable_in <= 1;
        n = 0;
        // Ready, read data and error are all taken at the same rising edge
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        if (pready_out !== 1'b1)
            mismatches++;
        q = prdata_out;
        e = pslverr_out;
        psel_in <= 0;
        penable_in <= 0;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] x, input string n);
        apb(0, a, 0);
        chk(n, x, q);
    endtask
    task vsel(input logic [7:0] x);
        u_twi_core_model.op(2);
        @(negedge clk_sys_in);
        chk("vector", {24'h0, x}, {24'h0, vector_low_out});
    endtask
    task trap(input logic [14:0] a, input logic [7:0] d, input logic x);
        u_twi_core_model.fetch(a, d);
        @(negedge clk_sys_in);
        chk("trap", x, trap_req_out);
        chk("fetch valid", 1, fetch_valid_out);
    endtask
    task settle;
        repeat (2) @(negedge clk_sys_in);
    endtask
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            mismatches++;
            wrap_up;
        end
    end
    initial begin
        repeat (16) @(posedge clk_sys_in);
        rstn_in <= 1;
        for (int i = 0; i < 5; i++)
            rd(12'(i * 4), 0, "reset value");
        rd(12'h014, 0, "unmapped");
        chk("slverr", 1, e);
        ext_pending_in <= 8'h01;
        trap(15'h0100, 8'h00, 1);
        chk("retpc", 15'h0100, trap_ret_pc_out);
        chk("irq", 1, irq_req_out);
        vsel(8'hfe);
        rd(12'h000, 0, "ctrl");
        apb(1, 12'h000, 1);
        vsel(8'hfe);
        u_twi_core_model.recover();
        vsel(8'hfa);
        trap(15'h0200, 8'h00, 1);
        vsel(8'hfe);
        u_twi_core_model.recover();
        u_twi_core_model.op(3);
        trap(15'h3000, 8'h5a, 1);
        chk("opcode", 0, fetch_opcode_out);
        u_twi_core_model.recover();
        trap(15'h0300, 8'h5a, 0);
        chk("opcode", 8'h5a, fetch_opcode_out);
        u_twi_core_model.op(0);
        @(negedge clk_sys_in);
        chk("pctop", 1, load_pc_top_out);
        ext_pending_in <= 8'h00;
        apb(1, 12'h004, 8'h85);
        apb(1, 12'h008, 8'h01);
        port_pins_in <= 8'h05;
        rd(12'h00c, 8'h81, "pending");
        port_pins_in <= 8'h80;
        rd(12'h00c, 8'h85, "pending hold");
        settle;
        chk("irq", 0, irq_req_out);
        apb(1, 12'h000, 3);
        settle;
        chk("irq", 1, irq_req_out);
        vsel(8'he2);
        halt_idle_in <= 1;
        settle;
        chk("service", 1, wake_service_out);
        apb(1, 12'h000, 1);
        settle;
        chk("service", 0, wake_service_out);
        chk("wake", 1, wake_out);
        apb(1, 12'h00c, 8'h85);
        rd(12'h00c, 0, "cleared");
        trap(15'h0400, 8'h00, 1);
        @(posedge clk_sys_in);
        rstn_in <= 0;
        repeat (2) @(posedge clk_sys_in);
        rstn_in <= 1;
        @(negedge clk_sys_in);
        chk("irq after reset", 0, irq_req_out);
        vsel(8'he0);
        wrap_up;
    end
endmodule
bind twi_trap_wakeup twi_trap_wakeup_sva #(.PC_W(PC_W), .ROM_TOP(ROM_TOP))
    u_twi_trap_wakeup_sva (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .ce_in(ce_in),
    .psel_in(psel_in), .penable_in(penable_in), .pready_out(pready_out),
    .fetch_valid_in(fetch_valid_in), .fetch_pc_in(fetch_pc_in), .rom_data_in(rom_data_in),
    .fetch_opcode_out(fetch_opcode_out), .stack_pop_under_in(stack_pop_under_in),
    .load_pc_top_out(load_pc_top_out), .vector_select_op_in(vector_select_op_in),
    .vector_low_out(vector_low_out), .vector_valid_out(vector_valid_out),
    .trap_req_out(trap_req_out), .trap_ret_pc_out(trap_ret_pc_out),
    .irq_req_out(irq_req_out), .wake_out(wake_out), .wake_service_out(wake_service_out));
`default_nettype wire
